/* File: rtl/pdcr_regs.sv */
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module pdcr_regs (
    // Clock and reset.
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Avalon-MM slave.
    input  wire logic [2:0]                avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic [31:0]                    avs_readdata_o,
    output logic                           avs_waitrequest_o,
    // Power control pins.
    input  wire logic                      en_i,
    input  wire logic [1:0]                auto_powerup_field_i,
    // Configuration towards the loops.
    output pdcr_pkg::pdcr_main_type        main_cfg_o,
    output pdcr_pkg::pdcr_ref_type         ref_cfg_o,
    output pdcr_pkg::pdcr_aux_type         aux_cfg_o,
    output pdcr_pkg::pdcr_auxcnt_type      aux_cnt_o,
    // Power state.
    output logic                           main_pd_o,
    output logic                           main_pump_hiz_o,
    output logic                           aux_pd_o
);
    import pdcr_pkg::*;

    //------------------------------------------------------------------
    // Declarations.
    //------------------------------------------------------------------
    logic            req;            // Read or write pending.
    logic            ack_ff;         // Answer cycle of a request.
    logic            wr_go;          // Write commits this edge.
    logic            prog_wr;        // Full programming word write.
    logic [23:0]     wd;             // Programming word on the bus.
    logic            sel_main;       // Word goes to main register.
    logic            sel_ref;        // Word goes to reference register.
    logic            sel_aux;        // Word goes to aux register.
    logic [23:0]     last_word_ff;   // Last word written.
    logic            unrouted_ff;    // Last word hit no register here.
    pdcr_main_type   main_ff;        // Main divider word.
    pdcr_ref_type    ref_ff;         // Reference word.
    pdcr_aux_type    aux_ff;         // Aux divider word.
    pdcr_aux_type    nxt_aux;        // Aux word as written.
    pdcr_auxcnt_type aux_cnt_ff;     // Aux counters.
    pdcr_auxcnt_type nxt_aux_cnt;    // Counters of the written word.
    logic            main_ok;        // Main value inside usable range.
    logic            aux_ok;         // Aux ratio legal.
    logic [31:0]     rd_mux;         // Read data selection.
    logic [31:0]     readdata_ff;    // Registered read data.

    //------------------------------------------------------------------
    // Bus handshake.
    //------------------------------------------------------------------
    // Every request waits exactly one cycle, then is answered.
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr_go             = avs_write_i & ack_ff;
    assign avs_readdata_o    = readdata_ff;

    // The acknowledge toggles so back to back requests each get a wait.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    //------------------------------------------------------------------
    // Word routing.
    //------------------------------------------------------------------
    // Only a write with all three low byte lanes is a programming word.
    assign wd       = avs_writedata_i[23:0];
    assign prog_wr  = wr_go && (avs_address_i == ADDR_PROG)
                      && (&avs_byteenable_i[2:0]);
    assign sel_main = ~wd[0];
    assign sel_ref  = (wd[3:0] == CTL_REF);
    assign sel_aux  = (wd[3:0] == CTL_AUX);

    // The last word is kept whatever its destination.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_word_ff <= 24'h000000;
            unrouted_ff  <= 1'b0;
        end else if (prog_wr) begin
            last_word_ff <= wd;
            unrouted_ff  <= ~(sel_main | sel_ref | sel_aux);
        end
    end

    // One write updates divider and numerator together.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_ff <= MAIN_RST;
        end else if (prog_wr && sel_main) begin
            main_ff <= wd[23:MAIN_LSB];
        end
    end

    // Reference divider, denominator and power-down bit.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_ff <= REF_RST;
        end else if (prog_wr && sel_ref) begin
            ref_ff <= {wd[23], wd[REF_FIX-1:DATA_LSB]};
        end
    end

    //------------------------------------------------------------------
    // Auxiliary divider.
    //------------------------------------------------------------------
    // Swallow is the value modulo the prescaler, main count the quotient.
    // With the low prescaler bit three is skipped, so the quotient sits
    // at bit four for both moduli.
    always_comb begin
        nxt_aux = wd[23:DATA_LSB];
        nxt_aux_cnt.main_cnt = nxt_aux.div[16:4];
        if (nxt_aux.presc_sel) begin
            nxt_aux_cnt.swallow = nxt_aux.div[3:0];
            nxt_aux_cnt.modulus = MOD_HIGH;
        end else begin
            nxt_aux_cnt.swallow = {1'b0, nxt_aux.div[2:0]};
            nxt_aux_cnt.modulus = MOD_LOW;
        end
    end

    // Word and its counters are stored on the same edge.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aux_ff     <= AUX_RST;
            aux_cnt_ff <= {13'h0000, 4'h0, MOD_LOW};
        end else if (prog_wr && sel_aux) begin
            aux_ff     <= nxt_aux;
            aux_cnt_ff <= nxt_aux_cnt;
        end
    end

    //------------------------------------------------------------------
    // Power control and legality.
    //------------------------------------------------------------------
    // Pin low wins, then auto power-up, then the power-down bit.
    always_comb begin
        if (!en_i) begin
            main_pd_o = 1'b1;
        end else if (auto_powerup_field_i != AUTO_POWERUP_FIELD_OFF) begin
            main_pd_o = 1'b0;
        end else begin
            main_pd_o = ref_ff.pd;
        end
    end

    // The pump floats whenever the main loop is down.
    assign main_pump_hiz_o = main_pd_o;
    assign aux_pd_o        = aux_ff.pd;

    // Flags only report; the host owns legal programming.
    assign main_ok = (main_ff.int_div >= MAIN_MIN)
                     && (main_ff.int_div <= MAIN_MAX);
    assign aux_ok  = (aux_cnt_ff.main_cnt >= {9'h000, aux_cnt_ff.swallow})
                     && (aux_cnt_ff.main_cnt >= AUX_MIN_B)
                     && (aux_ff.presc_sel || !aux_ff.div[3]);

    assign main_cfg_o = main_ff;
    assign ref_cfg_o  = ref_ff;
    assign aux_cfg_o  = aux_ff;
    assign aux_cnt_o  = aux_cnt_ff;

    //------------------------------------------------------------------
    // Read path.
    //------------------------------------------------------------------
    // Unmapped addresses read zero.
    always_comb begin
        case (avs_address_i)
            ADDR_PROG:   rd_mux = {8'h00, last_word_ff};
            ADDR_MAIN:   rd_mux = {8'h00, main_ff, 1'b0};
            ADDR_REF:    rd_mux = {8'h00, ref_ff.pd, 1'b1,
                                   ref_ff.ref_div, ref_ff.frac_den,
                                   CTL_REF};
            ADDR_AUX:    rd_mux = {8'h00, aux_ff, CTL_AUX};
            ADDR_STATUS: rd_mux = {27'h0000000, unrouted_ff, aux_ok,
                                   main_ok, aux_ff.pd, main_pd_o};
            ADDR_AUXCNT: rd_mux = {10'h000, aux_cnt_ff};
            default:     rd_mux = 32'h00000000;
        endcase
    end

    // Read data is caught in the wait cycle and stands in the answer.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata_ff <= 32'h00000000;
        end else if (avs_read_i && !ack_ff) begin
            readdata_ff <= rd_mux;
        end
    end

    //------------------------------------------------------------------
    // Checks.
    //------------------------------------------------------------------
    property p_main_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        (prog_wr && !wd[0]) |=> (main_ff == $past(wd[23:1]));
    endproperty
    a_main_route: assert property (p_main_route)
        else $error("Main word not loaded from a word with LSB zero.");

    property p_main_binary;
        @(posedge clk_i) disable iff (!rst_n_i)
        (prog_wr && !wd[0]) |=> ##1
            (main_cfg_o.int_div == $past(avs_writedata_i[23:13], 2));
    endproperty
    a_main_binary: assert property (p_main_binary)
        else $error("Main integer divider differs from written value.");

    property p_ref_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        (prog_wr && wd[3:0] == CTL_REF) |=>
            (ref_cfg_o.ref_div == $past(wd[21:16]));
    endproperty
    a_ref_route: assert property (p_ref_route)
        else $error("Reference divider not loaded.");

    property p_aux_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        (prog_wr && wd[3:0] != CTL_AUX) |=> $stable(aux_ff);
    endproperty
    a_aux_route: assert property (p_aux_route)
        else $error("Aux word changed by a word for another register.");

    // A word with an unknown control code touches no divider register and sets the unrouted flag.
    property p_unrouted;
        @(posedge clk_i) disable iff (!rst_n_i)
        (prog_wr && wd[0] && wd[3:0] != CTL_REF && wd[3:0] != CTL_AUX)
            |=> ($stable(main_ff) && $stable(ref_ff) && unrouted_ff);
    endproperty
    a_unrouted: assert property (p_unrouted)
        else $error("Word with an unknown control code was stored.");

    property p_en_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        !en_i |-> (main_pd_o && main_pump_hiz_o);
    endproperty
    a_en_low: assert property (p_en_low)
        else $error("Main loop up while enable pin is low.");

    property p_auto_powerup_field;
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_i && auto_powerup_field_i != AUTO_POWERUP_FIELD_OFF) |-> !main_pd_o;
    endproperty
    a_auto_powerup_field: assert property (p_auto_powerup_field)
        else $error("Auto power-up did not power the main loop.");

    property p_pd_bit;
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_i && auto_powerup_field_i == AUTO_POWERUP_FIELD_OFF) |->
            (main_pd_o == ref_ff.pd);
    endproperty
    a_pd_bit: assert property (p_pd_bit)
        else $error("Power-down bit ignored.");

    property p_pd_one;
        @(posedge clk_i) disable iff (!rst_n_i)
        (en_i && auto_powerup_field_i == AUTO_POWERUP_FIELD_OFF && ref_cfg_o.pd)
            |-> main_pump_hiz_o;
    endproperty
    a_pd_one: assert property (p_pd_one)
        else $error("Pump not floating with power-down bit set.");

    property p_split;
        @(posedge clk_i) disable iff (!rst_n_i)
        (prog_wr && sel_aux) |=>
            ({aux_cnt_o.main_cnt, 4'h0} + {13'h0000, aux_cnt_o.swallow}
             == {$past(wd[20:8]), 4'h0}
                + {13'h0000, $past(wd[7]), $past(wd[6:4])
                   & {3{1'b1}}} - {16'h0000, !$past(wd[22])
                   && $past(wd[7])});
    endproperty
    a_split: assert property (p_split)
        else $error("Aux counters do not match written divider.");

    property p_presc;
        @(posedge clk_i) disable iff (!rst_n_i)
        aux_cnt_o.modulus == (aux_cfg_o.presc_sel ? MOD_HIGH : MOD_LOW);
    endproperty
    a_presc: assert property (p_presc)
        else $error("Prescaler modulus does not follow select bit.");

endmodule // pdcr_regs

/* File: rtl/pdcr_pkg.sv */
//----------------------------------------------------------------------
// Shared constants and types of the divider configuration bank.
//----------------------------------------------------------------------
package pdcr_pkg;

    // Word addresses of the Avalon-MM register map.
    localparam logic [2:0] ADDR_PROG   = 3'h0; // Serial word entry.
    localparam logic [2:0] ADDR_MAIN   = 3'h1; // Main divider readback.
    localparam logic [2:0] ADDR_REF    = 3'h2; // Reference word readback.
    localparam logic [2:0] ADDR_AUX    = 3'h3; // Aux divider readback.
    localparam logic [2:0] ADDR_STATUS = 3'h4; // Power and legality.
    localparam logic [2:0] ADDR_AUXCNT = 3'h5; // Aux counter split.

    // Control codes in the low bits of a programming word.
    localparam logic [3:0] CTL_REF    = 4'h1; // Reference word.
    localparam logic [3:0] CTL_AUX    = 4'h3; // Aux divider word.
    localparam int         MAIN_LSB   = 1;    // Main word data start.
    localparam int         DATA_LSB   = 4;    // Other words data start.
    localparam int         REF_FIX    = 22;   // Fixed one bit, ref word.

    // Auto power-up code that leaves the power-down bit in charge.
    localparam logic [1:0] AUTO_POWERUP_FIELD_OFF   = 2'h0;

    // Prescaler moduli of the auxiliary divider.
    localparam logic [4:0] MOD_LOW    = 5'h08; // Select bit low.
    localparam logic [4:0] MOD_HIGH   = 5'h10; // Select bit high.

    // Usable limits of the divide values.
    localparam logic [10:0] MAIN_MIN  = 11'h041; // 65.
    localparam logic [10:0] MAIN_MAX  = 11'h7fd; // 2045.
    localparam logic [12:0] AUX_MIN_B = 13'h0003; // Least main count.

    // Status register bit positions.
    localparam int ST_MAIN_PD  = 0;
    localparam int ST_AUX_PD   = 1;
    localparam int ST_MAIN_OK  = 2;
    localparam int ST_AUX_OK   = 3;
    localparam int ST_UNROUTED = 4;

    // Main divider and fractional numerator word.
    typedef struct packed {
        logic [10:0] int_div;
        logic [11:0] frac_num;
    } pdcr_main_type;

    // Reference divider, denominator and main power-down word.
    typedef struct packed {
        logic        pd;
        logic [5:0]  ref_div;
        logic [11:0] frac_den;
    } pdcr_ref_type;

    // Auxiliary divider word.
    typedef struct packed {
        logic        pd;
        logic        presc_sel;
        logic        pump_gain;
        logic [16:0] div;
    } pdcr_aux_type;

    // Auxiliary divider split into its counters.
    typedef struct packed {
        logic [12:0] main_cnt;
        logic [3:0]  swallow;
        logic [4:0]  modulus;
    } pdcr_auxcnt_type;

    // Reset values: both power-down bits come up set.
    localparam logic [22:0] MAIN_RST = 23'h000000;
    localparam logic [18:0] REF_RST  = 19'h40000;
    localparam logic [19:0] AUX_RST  = 20'h80000;

endpackage

/* File: testbench/pdcr_host.sv */
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Host model: an Avalon-MM master that writes programming words.
//----------------------------------------------------------------------
module pdcr_host (
    // Clock.
    input  wire logic        clk_i,
    // Avalon-MM master side.
    output logic [2:0]       address_o,
    output logic             read_o,
    output logic             write_o,
    output logic [31:0]      writedata_o,
    output logic [3:0]       byteenable_o,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i
);
    logic [31:0] rd_data; // Read data taken at the end of the last completed access, read or write.

    // The bus is idle at time zero.
    initial begin
        address_o = 3'h0;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0;
        byteenable_o = 4'hf;
    end

    // One bus cycle; the request is held until waitrequest is low.
    task automatic access(input logic wr, input logic [2:0] a,
                          input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_i);
        address_o <= a;
        read_o <= ~wr;
        write_o <= wr;
        writedata_o <= d;
        byteenable_o <= be;
        @(posedge clk_i);
        while (waitrequest_i) @(posedge clk_i);
        rd_data = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
        writedata_o <= ~d; // Released data never shows a stale copy.
    endtask

    // Picks a main value usable with any modulator order.
    function automatic logic [10:0] main_pick(input logic [31:0] r);
        return 11'd71 + 11'(r % 32'd1969);
    endfunction

    // Encodes an aux value; the fourth bit is zero for the low modulus.
    function automatic logic [16:0] aux_div(input logic [16:0] n,
                                            input logic sel);
        return sel ? n : {n[15:3], 1'b0, n[2:0]};
    endfunction
endmodule // pdcr_host

/* File: testbench/pdcr_regs_tb.sv */
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Testbench of the divider configuration bank.
//----------------------------------------------------------------------
module pdcr_regs_tb;
    import pdcr_pkg::*;
    // One expected result noted for the monitor.
    typedef struct packed {
        logic [2:0]  kind;
        logic [31:0] mask;
        logic [31:0] val;
    } pdcr_note_type;
    logic            clk_i = 1'b0;
    logic            rst_n_i = 1'b0;
    logic [2:0]      avs_address_i;
    logic            avs_read_i, avs_write_i;
    logic [31:0]     avs_writedata_i, avs_readdata_o;
    logic [3:0]      avs_byteenable_i;
    logic            avs_waitrequest_o;
    logic            en_i = 1'b1;
    logic [1:0]      auto_powerup_field_i = 2'h0;
    pdcr_main_type   main_cfg_o;
    pdcr_ref_type    ref_cfg_o;
    pdcr_aux_type    aux_cfg_o;
    pdcr_auxcnt_type aux_cnt_o;
    logic            main_pd_o, main_pump_hiz_o, aux_pd_o;
    pdcr_note_type   note_q[$];     // Pending expected results.
    pdcr_note_type   note;          // Note being compared.
    event            look;          // A result is ready to be seen.
    int              fails = 0, compares = 0, cycles = 0, i;
    logic [31:0]     seed = 32'hdc4b4e72, seen, b, a, lm, lr, la;
    logic [10:0]     n;
    logic [11:0]     f;
    logic [16:0]     nv, dv;
    logic [4:0]      p;
    logic            ex;
    string names[6] = '{"readdata", "main_cfg", "ref_cfg", "aux_cfg",
                        "aux_cnt", "pins"};
    // Legal aux values: low modulus first, then the high one.
    logic [16:0] aux_n[5] = '{17'd24, 17'd54, 17'd65535,
                              17'd48, 17'h1ffff};

    // Clock of 50 ns period.
    always #25 clk_i = ~clk_i;

    pdcr_regs dut (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
        .avs_readdata_o, .avs_waitrequest_o, .en_i, .auto_powerup_field_i,
        .main_cfg_o, .ref_cfg_o, .aux_cfg_o, .aux_cnt_o, .main_pd_o,
        .main_pump_hiz_o, .aux_pd_o);

    pdcr_host host (.clk_i(clk_i), .address_o(avs_address_i),
        .read_o(avs_read_i), .write_o(avs_write_i),
        .writedata_o(avs_writedata_i), .byteenable_o(avs_byteenable_i),
        .readdata_i(avs_readdata_o), .waitrequest_i(avs_waitrequest_o));

    // Xorshift source of random values.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Notes one expected result and lets the monitor see it.
    task automatic expect_val(input logic [2:0] k,
                              input logic [31:0] m, v);
        note_q.push_back('{k, m, v});
        -> look;
        #1;
    endtask

    // Lets one edge pass so outputs have settled.
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Monitor: takes the oldest note and compares the named output.
    always @(look) begin
        note = note_q.pop_front();
        case (note.kind)
            3'h0: seen = host.rd_data;
            3'h1: seen = {9'h0, main_cfg_o};
            3'h2: seen = {13'h0, ref_cfg_o};
            3'h3: seen = {12'h0, aux_cfg_o};
            3'h4: seen = {10'h0, aux_cnt_o};
            default: seen = {29'h0, main_pd_o, main_pump_hiz_o, aux_pd_o};
        endcase
        check(names[note.kind], seen & note.mask, note.val);
    end

    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            print_verdict();
        end
    end

    // Main sequence.
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        expect_val(3'h5, 32'h7, 32'h7);
        host.access(1'b0, ADDR_STATUS, 32'h0, 4'hf);
        expect_val(3'h0, 32'h1f, 32'h3);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            n = (i == 0) ? 11'd65 : (i == 1) ? 11'd2045 :
                host.main_pick(rnd());
            f = 12'(rnd());
            lm = {9'h0, n, f};
            host.access(1'b1, ADDR_PROG, {8'h0, n, f, 1'b0}, 4'hf);
            settle();
            expect_val(3'h1, '1, lm);
        end
        host.access(1'b1, ADDR_PROG, {8'h0, 11'd99, 12'h0, 1'b0}, 4'h3);
        settle();
        expect_val(3'h1, '1, lm);
        $display("test main done");
        for (i = 0; i < 2; i++) begin
            f = 12'(rnd());
            lr = {13'h0, 1'b0, i ? 6'd63 : 6'd1, f};
            host.access(1'b1, ADDR_PROG,
                {8'h0, 2'b01, lr[17:0], CTL_REF}, 4'hf);
            settle();
            expect_val(3'h2, '1, lr);
        end
        for (i = 0; i < 16; i++) begin
            host.access(1'b1, ADDR_PROG,
                {8'h0, i[3], 1'b1, 6'd5, 12'h0, CTL_REF}, 4'hf);
            en_i <= i[2];
            auto_powerup_field_i <= i[1:0];
            settle();
            ex = !i[2] ? 1'b1 : (i[1:0] != 2'h0) ? 1'b0 : i[3];
            expect_val(3'h5, 32'h6, {29'h0, ex, ex, 1'b0});
        end
        lr = {13'h0, 1'b1, 6'd5, 12'h0};
        en_i <= 1'b1;
        auto_powerup_field_i <= 2'h0;
        $display("test power done");
        for (i = 0; i < 5; i++) begin
            nv = aux_n[i];
            p = (i > 2) ? 5'h10 : 5'h08;
            dv = host.aux_div(nv, i > 2);
            b = 32'(nv) / 32'(p);
            a = 32'(nv) % 32'(p);
            la = {12'h0, i[0], i > 2, i[1], dv};
            host.access(1'b1, ADDR_PROG, {8'h0, la[19:0], CTL_AUX}, 4'hf);
            settle();
            expect_val(3'h3, '1, la);
            expect_val(3'h4, '1, {10'h0, b[12:0], a[3:0], p});
            expect_val(3'h5, 32'h1, {31'h0, i[0]});
        end
        $display("test aux done");
        host.access(1'b1, ADDR_PROG, 32'h00abcd05, 4'hf);
        settle();
        expect_val(3'h1, '1, lm);
        expect_val(3'h2, '1, lr);
        expect_val(3'h3, '1, la);
        host.access(1'b0, 3'h7, 32'h0, 4'hf);
        expect_val(3'h0, '1, 32'h0);
        $display("test routing done");
        // Every readback address, and the unrouted flag in the status.
        host.access(1'b0, ADDR_STATUS, 32'h0, 4'hf);
        expect_val(3'h0, 32'h1f, 32'h1d);
        host.access(1'b0, ADDR_PROG, 32'h0, 4'hf);
        expect_val(3'h0, '1, 32'h00abcd05);
        host.access(1'b0, ADDR_MAIN, 32'h0, 4'hf);
        expect_val(3'h0, '1, {8'h0, lm[22:0], 1'b0});
        host.access(1'b0, ADDR_REF, 32'h0, 4'hf);
        expect_val(3'h0, '1, {8'h0, lr[18], 1'b1, lr[17:0], CTL_REF});
        host.access(1'b0, ADDR_AUX, 32'h0, 4'hf);
        expect_val(3'h0, '1, {8'h0, la[19:0], CTL_AUX});
        host.access(1'b0, ADDR_AUXCNT, 32'h0, 4'hf);
        expect_val(3'h0, '1, {10'h0, b[12:0], a[3:0], p});
        $display("test readback done");
        // A reset in mid-run brings every register back to its start.
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        expect_val(3'h1, '1, {9'h0, MAIN_RST});
        expect_val(3'h2, '1, {13'h0, REF_RST});
        expect_val(3'h3, '1, {12'h0, AUX_RST});
        expect_val(3'h4, '1, {10'h0, 17'h0, MOD_LOW});
        expect_val(3'h5, 32'h7, 32'h7);
        $display("test second reset done");
        print_verdict();
    end
endmodule // pdcr_regs_tb
